// ---- hw/eeenp_pkg.sv ----
package eeenp_pkg;
  // direct switch register addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h6E; // indirect control byte
  localparam logic [7:0] ADDR_OFFS   = 8'h6F; // indirect offset byte
  localparam logic [7:0] ADDR_DATA   = 8'hA0; // indirect data byte
  // control byte fields
  localparam int         TABLE_MSB   = 7;
  localparam int         TABLE_LSB   = 5;
  localparam int         PORT_MSB    = 3;
  localparam logic [2:0] TABLE_EEE   = 3'h1;
  localparam logic [3:0] PORT_FIRST  = 4'h1;
  // indirect offsets inside the eee table
  localparam logic [7:0] OFF_TX_HI   = 8'h0E;
  localparam logic [7:0] OFF_TX_LO   = 8'h0F;
  localparam logic [7:0] OFF_RX_HI   = 8'h10;
  localparam logic [7:0] OFF_RX_LO   = 8'h11;
  // page layout
  localparam int         CODE_W      = 11;
  localparam logic [10:0] CODE_RESET = 11'h001; // code field after reset
  localparam logic [10:0] AUTO_CODE  = 11'h00A; // eee message code sent in auto mode
  localparam logic [1:0] ACK_BURSTS  = 2'h3;    // consistent bursts before ack
  localparam logic [7:0] BYTE_ZERO   = 8'h00;

  // one 16-bit next page, msb first
  typedef struct packed {
    logic              more_pages_follow; // 15
    logic              ack;               // 14, reserved in transmit view
    logic              message_page_flag; // 13
    logic              will_comply_flag;  // 12
    logic              toggle;            // 11
    logic [CODE_W-1:0] code;              // 10..0
  } eeenp_page_t;

  // per-port events from the negotiation arbiter
  typedef struct packed {
    logic        base_done;   // base codeword exchanged, pulse
    logic        base_toggle; // bit 11 of that base codeword
    logic        page_sent;   // one next page exchanged, pulse
    logic        burst_valid; // received burst decoded, pulse
    logic [15:0] burst_word;  // decoded burst word
  } eeenp_link_in_t;
endpackage : eeenp_pkg

// ---- hw/eeenp_port.sv ----
`timescale 1ns/1ps
module eeenp_port
  import eeenp_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           resetn,
  input  wire logic           auto_eee,
  input  wire logic           wr_hi,
  input  wire logic           wr_lo,
  input  wire logic [7:0]     wbyte,
  input  wire eeenp_link_in_t link,
  output eeenp_page_t         tx_reg,
  output eeenp_page_t         tx_page,
  output eeenp_page_t         rx_reg
);
  logic              more_pages_follow; // writable fields
  logic              message_page_flag;
  logic              will_comply_flag;
  logic [CODE_W-1:0] code;
  logic              toggle;            // hardware owned
  logic [15:0]       last_word;         // previous burst
  logic [1:0]        match_cnt;         // consecutive consistent bursts
  logic              burst_match;

  ////////////////////////////////////////////////////////////////////
  // software writable fields, byte wise
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      more_pages_follow <= 1'b0;          // see R5
      message_page_flag <= 1'b1;          // see R6
      will_comply_flag  <= 1'b0;          // see R7
      code              <= CODE_RESET;    // see R10
    end else begin
      if (wr_hi) begin
        // bit 14 and toggle ignore writes
        more_pages_follow <= wbyte[7];    // see R5
        message_page_flag <= wbyte[5];    // see R6
        will_comply_flag  <= wbyte[4];    // see R7
        code[10:8]        <= wbyte[2:0];  // see R10
      end
      if (wr_lo) begin
        code[7:0] <= wbyte;               // see R10
      end
    end
  end

  // toggle: seeded from base codeword, then flips per page
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      toggle <= 1'b0;
    end else if (link.base_done) begin
      toggle <= ~link.base_toggle;        // see R9
    end else if (link.page_sent) begin
      toggle <= ~toggle;                  // see R8
    end
  end

  // register view; reserved bit reads zero
  always_comb begin
    tx_reg = '{more_pages_follow, 1'b0, message_page_flag, will_comply_flag, toggle, code}; // see R12
  end

  ////////////////////////////////////////////////////////////////////
  // page handed to the arbiter, registered
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_page <= '0;
    end else if (auto_eee) begin
      // auto mode: built-in eee message page, single page
      tx_page <= '{1'b0, 1'b0, 1'b1, 1'b0, toggle, AUTO_CODE}; // see R4
    end else begin
      tx_page <= tx_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // consistency ignores the ack bit itself
  assign burst_match = (link.burst_word[15] == last_word[15])
                    && (link.burst_word[13:0] == last_word[13:0]);

  // burst history counter, saturates
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_word <= 16'h0000;
      match_cnt <= 2'h0;
    end else if (link.burst_valid) begin
      last_word <= link.burst_word;
      if (!burst_match || match_cnt == 2'h0) begin
        match_cnt <= 2'h1;                // see R13
      end else if (match_cnt != ACK_BURSTS) begin
        match_cnt <= match_cnt + 2'h1;    // see R13
      end
    end
  end

  // partner page latched with ack once consistent
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_reg <= '0;
    end else if (link.burst_valid && burst_match && match_cnt == ACK_BURSTS - 2'h1) begin
      rx_reg     <= link.burst_word;      // see R13
      rx_reg.ack <= 1'b1;                 // see R13
    end
  end

  ////////////////////////////////////////////////////////////////////
  toggle_seed_a: assert property (@(posedge clk) disable iff (!resetn) // see R9
    link.base_done |=> tx_reg.toggle == !$past(link.base_toggle))
    else $error("toggle not seeded from base codeword");

  toggle_flip_a: assert property (@(posedge clk) disable iff (!resetn) // see R8
    (link.page_sent && !link.base_done) |=> tx_reg.toggle != $past(tx_reg.toggle))
    else $error("toggle did not flip after page");

  reserved_zero_a: assert property (@(posedge clk) disable iff (!resetn) // see R12
    !tx_reg.ack)
    else $error("reserved bit reads nonzero");

  sequence three_bursts_s;
    (link.burst_valid && burst_match && match_cnt == 2'h2);
  endsequence
  ack_set_a: assert property (@(posedge clk) disable iff (!resetn) // see R13
    three_bursts_s |=> rx_reg.ack && rx_reg.code == $past(link.burst_word[10:0]))
    else $error("ack not set after three bursts");

  auto_page_a: assert property (@(posedge clk) disable iff (!resetn) // see R4
    auto_eee |=> tx_page.code == AUTO_CODE && tx_page.message_page_flag)
    else $error("auto page not sent");
endmodule : eeenp_port

// ---- hw/eeenp_regs.sv ----
`timescale 1ns/1ps
// How it works
// R1: control byte selects eee table and port
// R2: offset byte picks byte, data byte accesses
// R3: transmit page upper at 0x0E, lower 0x0F
// R4: auto eee bit sends page by itself
// R5: bit 15 more pages follow, resets zero
// R6: bit 13 message page flag, resets one
// R7: bit 12 will comply flag, resets zero
// R8: toggle flips each page, read only
// R9: first toggle inverts base codeword bit 11
// R10: code field bits 10-0, resets one
// R11: partner receive page at 0x10, 0x11
// R12: transmit bit 14 reads zero, ignores writes
// R13: ack after three consistent bursts
module eeenp_regs
  import eeenp_pkg::*;
#(
  parameter int NPORTS = 4
) (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [7:0]                  reg_rdata,
  input  wire logic                        auto_eee,
  input  wire eeenp_link_in_t [NPORTS-1:0] link_in,
  output eeenp_page_t [NPORTS-1:0]         tx_page
);
  logic [7:0]                  ctrl_byte;    // indirect control
  logic [7:0]                  offs_byte;    // indirect offset
  eeenp_page_t [NPORTS-1:0]    tx_reg;       // per-port transmit view
  eeenp_page_t [NPORTS-1:0]    rx_reg;       // per-port partner page
  logic [NPORTS-1:0]           wr_hi;        // per-port byte strobes
  logic [NPORTS-1:0]           wr_lo;
  logic                        data_wr;      // write to data byte
  logic [7:0]                  next_rdata;

  ////////////////////////////////////////////////////////////////////
  // decode helpers, used by write and read paths
  function automatic logic table_hit(input logic [7:0] c);
    table_hit = (c[TABLE_MSB:TABLE_LSB] == TABLE_EEE);
  endfunction : table_hit

  function automatic logic port_hit(input logic [7:0] c, input logic [3:0] idx);
    port_hit = table_hit(c) && (c[PORT_MSB:0] == idx + PORT_FIRST);
  endfunction : port_hit

  // selector names the eee table and a port that exists
  function automatic logic sel_valid(input logic [7:0] c);
    sel_valid = 1'b0;
    for (int q = 0; q < NPORTS; q++) begin
      if (port_hit(c, 4'(q))) begin
        sel_valid = 1'b1;                 // some port answers
      end
    end
  endfunction : sel_valid

  // byte of a port's registers for one offset, zero elsewhere
  function automatic logic [7:0] pick_byte(input eeenp_page_t t, input eeenp_page_t r,
                                           input logic [7:0] o);
    unique case (o)
      OFF_TX_HI: pick_byte = t[15:8];
      OFF_TX_LO: pick_byte = t[7:0];
      OFF_RX_HI: pick_byte = r[15:8];
      OFF_RX_LO: pick_byte = r[7:0];
      default:   pick_byte = BYTE_ZERO;
    endcase
  endfunction : pick_byte

  ////////////////////////////////////////////////////////////////////
  // direct control and offset bytes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_byte <= BYTE_ZERO;
    end else if (reg_wr && reg_addr == ADDR_CTRL) begin
      ctrl_byte <= reg_wdata;             // see R1
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      offs_byte <= BYTE_ZERO;
    end else if (reg_wr && reg_addr == ADDR_OFFS) begin
      offs_byte <= reg_wdata;             // see R2
    end
  end

  // data byte write strobe, decoded once and shared by every port slice
  assign data_wr = reg_wr && (reg_addr == ADDR_DATA);

  ////////////////////////////////////////////////////////////////////
  // one register slice per port
  for (genvar i = 0; i < NPORTS; i++) begin : g_port
    // only transmit bytes are writable; receive page is read only
    assign wr_hi[i] = data_wr && port_hit(ctrl_byte, 4'(i)) && offs_byte == OFF_TX_HI; // see R3
    assign wr_lo[i] = data_wr && port_hit(ctrl_byte, 4'(i)) && offs_byte == OFF_TX_LO; // see R3

    eeenp_port u_port (
      .clk      (clk),
      .resetn   (resetn),
      .auto_eee (auto_eee),
      .wr_hi    (wr_hi[i]),
      .wr_lo    (wr_lo[i]),
      .wbyte    (reg_wdata),
      .link     (link_in[i]),
      .tx_reg   (tx_reg[i]),
      .tx_page  (tx_page[i]),
      .rx_reg   (rx_reg[i])
    );
  end

  ////////////////////////////////////////////////////////////////////
  // read mux; unselected table, port or offset reads zero
  always_comb begin
    next_rdata = BYTE_ZERO;
    unique case (reg_addr)
      ADDR_CTRL: next_rdata = ctrl_byte;
      ADDR_OFFS: next_rdata = offs_byte;
      ADDR_DATA: begin
        // at most one port can match, so the loop order does not matter
        for (int p = 0; p < NPORTS; p++) begin
          if (port_hit(ctrl_byte, 4'(p))) begin
            next_rdata = pick_byte(tx_reg[p], rx_reg[p], offs_byte); // see R2 see R3 see R11
          end
        end
      end
      default: next_rdata = BYTE_ZERO;
    endcase
  end

  // read data registered, held between reads
  // holding it lets a slow master fetch the byte any time before its next read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= BYTE_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // selector aimed at the eee table, first port
  sequence sel_port1_s;
    ctrl_byte == {TABLE_EEE, 1'b0, PORT_FIRST};
  endsequence

  // a read of the indirect data byte
  sequence data_read_s;
    reg_rd && reg_addr == ADDR_DATA;
  endsequence

  // selector must keep what software wrote
  ctrl_store_a: assert property (@(posedge clk) disable iff (!resetn) // see R1
    (reg_wr && reg_addr == ADDR_CTRL) |=> ctrl_byte == $past(reg_wdata))
    else $error("control byte not stored");

  // offset byte steers every later data access
  offs_store_a: assert property (@(posedge clk) disable iff (!resetn) // see R2
    (reg_wr && reg_addr == ADDR_OFFS) |=> offs_byte == $past(reg_wdata))
    else $error("offset byte not stored");

  // read returns the byte as it stood before its own edge
  tx_hi_read_a: assert property (@(posedge clk) disable iff (!resetn) // see R3
    (sel_port1_s and (reg_rd && reg_addr == ADDR_DATA && offs_byte == OFF_TX_HI && !reg_wr))
    |=> reg_rdata == $past(tx_reg[0][15:8]))
    else $error("transmit upper byte misread");

  // partner page is reachable through the same data byte
  rx_lo_read_a: assert property (@(posedge clk) disable iff (!resetn) // see R11
    (sel_port1_s and (reg_rd && reg_addr == ADDR_DATA && offs_byte == OFF_RX_LO))
    |=> reg_rdata == $past(rx_reg[0][7:0]))
    else $error("partner lower byte misread");

  // other tables must never disturb the port registers
  wrong_table_a: assert property (@(posedge clk) disable iff (!resetn) // see R1
    (!table_hit(ctrl_byte)) |-> wr_hi == '0 && wr_lo == '0)
    else $error("write reached port outside eee table");

  // wrong table or a port out of range reads zero
  bad_select_a: assert property (@(posedge clk) disable iff (!resetn) // see R1
    (data_read_s and !sel_valid(ctrl_byte)) |=> reg_rdata == BYTE_ZERO)
    else $error("unselected port read nonzero");

  // offsets outside the four mapped bytes read zero
  bad_offset_a: assert property (@(posedge clk) disable iff (!resetn) // see R2
    (data_read_s and (offs_byte != OFF_TX_HI && offs_byte != OFF_TX_LO
                      && offs_byte != OFF_RX_HI && offs_byte != OFF_RX_LO)) |=> reg_rdata == BYTE_ZERO)
    else $error("unmapped offset read nonzero");

  // direct addresses other than the three bytes read zero
  unmapped_read_a: assert property (@(posedge clk) disable iff (!resetn) // see R2
    (reg_rd && reg_addr != ADDR_CTRL && reg_addr != ADDR_OFFS && reg_addr != ADDR_DATA)
    |=> reg_rdata == BYTE_ZERO)
    else $error("unmapped address read nonzero");

  // read data only moves on a read
  rdata_hold_a: assert property (@(posedge clk) disable iff (!resetn) // see R2
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  // low byte write lands whole in the code field
  tx_lo_write_a: assert property (@(posedge clk) disable iff (!resetn) // see R10
    (sel_port1_s and (data_wr && offs_byte == OFF_TX_LO))
    |=> tx_reg[0][7:0] == $past(reg_wdata))
    else $error("code field low byte not written");

  // high byte write sets more pages follow and the message page flag, reserved bit stays clear
  tx_hi_write_a: assert property (@(posedge clk) disable iff (!resetn) // see R12
    (sel_port1_s and (data_wr && offs_byte == OFF_TX_HI))
    |=> tx_reg[0].more_pages_follow == $past(reg_wdata[7]) && !tx_reg[0].ack
        && tx_reg[0].message_page_flag == $past(reg_wdata[5]))
    else $error("transmit upper byte not written");

  // without auto mode the arbiter sees the software page a cycle later
  tx_page_follow_a: assert property (@(posedge clk) disable iff (!resetn) // see R4
    !auto_eee |=> tx_page[0] == $past(tx_reg[0]))
    else $error("transmit page does not follow register");

  // the register comes out of reset as a single message page
  reset_value_a: assert property (@(posedge clk) // see R5 see R6 see R10
    $rose(resetn) |-> tx_reg[0] == {1'b0, 1'b0, 1'b1, 1'b0, 1'b0, CODE_RESET})
    else $error("transmit register reset value wrong");
endmodule : eeenp_regs

// ---- verification/eeenp_partner.sv ----
`timescale 1ns/1ps
module eeenp_partner
  import eeenp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [1:0]  cmd,
  input  wire logic        bit_in,
  input  wire logic [15:0] word,
  output eeenp_link_in_t   link
);
  logic [15:0] last_word; // last burst sent
  ////////////////////////////////////////
  // one event per command, pulses last one cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link      <= '0;
      last_word <= 16'h0000;
    end else begin
      link.base_done   <= (cmd == 2'h1);
      link.page_sent   <= (cmd == 2'h2);
      link.burst_valid <= (cmd == 2'h3);
      if (cmd == 2'h1) link.base_toggle <= bit_in;
      if (cmd == 2'h3) begin
        link.burst_word <= word;
        last_word       <= word;
      end else begin
        // word not valid outside a burst, so never show the stale one
        link.burst_word <= ~last_word;
      end
    end
  end
endmodule : eeenp_partner

// ---- verification/tb_eee_next_page_transmit_regs.sv ----
`timescale 1ns/1ps
module tb_eee_next_page_transmit_regs;
  import eeenp_pkg::*;
  logic clk, resetn, reg_wr, reg_rd, auto_eee, bit_in;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, r, wh, wl;
  logic [15:0] word, lw;       // bench value, word shown by the partners
  logic [1:0]  cmd [4];        // partner command per port
  logic        tg  [4];        // expected toggle per port
  wire eeenp_link_in_t [3:0] link_in; // each element driven by its own partner
  eeenp_page_t    [3:0] tx_page;
  int err_total, cmp_count, cyc, p;
  int seed = 90599;
  ////////////////////////////////////////
  eeenp_regs #(.NPORTS(4)) DUT (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .auto_eee(auto_eee), .link_in(link_in), .tx_page(tx_page));
  for (genvar g = 0; g < 4; g++) begin : g_lp
    eeenp_partner u_lp (.clk(clk), .resetn(resetn), .cmd(cmd[g]), .bit_in(bit_in),
      .word(lw), .link(link_in[g]));
  end
  ////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk
  // upper byte as it reads back: bit 14 zero, toggle from hardware
  function automatic logic [7:0] exp_hi(input logic [7:0] w, input logic t);
    return {w[7], 1'b0, w[5:4], t, w[2:0]};
  endfunction : exp_hi
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    #1 d = reg_rdata;
  endtask : rd
  // select table and port, then byte offset; the data byte access is left to the caller
  task automatic sel(input logic [2:0] tb, input logic [3:0] pt, input logic [7:0] off);
    wr(ADDR_CTRL, {tb, 1'b0, pt});
    wr(ADDR_OFFS, off);
  endtask : sel
  task automatic ev(input int q, input logic [1:0] c, input logic b, input logic [15:0] w);
    @(posedge clk);
    cmd[q] <= c;
    bit_in <= b;
    lw     <= w;
    @(posedge clk);
    cmd[q] <= 2'h0;
  endtask : ev
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////
  // main sequence
  initial begin
    {resetn, reg_wr, reg_rd, auto_eee, bit_in} = 5'h00;
    reg_addr = 8'h00; reg_wdata = 8'h00; word = 16'h0000;
    lw = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      cmd[i] = 2'h0;
      tg[i]  = 1'b0;
    end
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 1; i <= 4; i++) begin
      sel(TABLE_EEE, 4'(i), OFF_TX_HI); rd(ADDR_DATA, r); chk(r, 8'h20);
      sel(TABLE_EEE, 4'(i), OFF_TX_LO); rd(ADDR_DATA, r); chk(r, 8'h01);
      sel(TABLE_EEE, 4'(i), OFF_RX_LO); rd(ADDR_DATA, r); chk(r, BYTE_ZERO);
    end
    // refused places: wrong table, port zero, port five, bad offset, unmapped
    sel(3'h2, 4'h1, OFF_TX_LO); rd(ADDR_DATA, r); chk(r, BYTE_ZERO);
    sel(TABLE_EEE, 4'h0, OFF_TX_LO); rd(ADDR_DATA, r); chk(r, BYTE_ZERO);
    sel(TABLE_EEE, 4'h5, OFF_TX_LO); rd(ADDR_DATA, r); chk(r, BYTE_ZERO);
    sel(TABLE_EEE, 4'h1, 8'h0D); rd(ADDR_DATA, r); chk(r, BYTE_ZERO);
    rd(8'h55, r); chk(r, BYTE_ZERO);
    // random pages per port, read back and seen on the transmit side
    for (int k = 0; k < 8; k++) begin
      p  = k % 4;
      wh = 8'($random(seed));
      wl = 8'($random(seed));
      sel(TABLE_EEE, 4'(p + 1), OFF_TX_HI); wr(ADDR_DATA, wh);
      wr(ADDR_OFFS, OFF_TX_LO); wr(ADDR_DATA, wl);
      rd(ADDR_DATA, r); chk(r, wl);
      wr(ADDR_OFFS, OFF_TX_HI); rd(ADDR_DATA, r); chk(r, exp_hi(wh, tg[p]));
      chk(tx_page[p], {exp_hi(wh, tg[p]), wl});
    end
    // toggle: first page inverts base bit 11, then flips per page
    for (int k = 0; k < 4; k++) begin
      ev(k, 2'h1, k[0], 16'h0000); tg[k] = ~k[0];
      repeat (4) @(posedge clk);
      #1 chk(tx_page[k].toggle, tg[k]);
      ev(k, 2'h2, 1'b0, 16'h0000); tg[k] = ~tg[k];
      sel(TABLE_EEE, 4'(k + 1), OFF_TX_HI); rd(ADDR_DATA, r);
      chk(r[3], tg[k]);
    end
    // bursts: a mismatch restarts the count, three equal but for bit 14 latch
    word = 16'($random(seed));
    wh = word[15:8];
    ev(2, 2'h3, 1'b0, word); ev(2, 2'h3, 1'b0, word);
    ev(2, 2'h3, 1'b0, ~word); ev(2, 2'h3, 1'b0, word ^ 16'h4000);
    ev(2, 2'h3, 1'b0, word);
    sel(TABLE_EEE, 4'h3, OFF_RX_HI); rd(ADDR_DATA, r); chk(r, BYTE_ZERO);
    ev(2, 2'h3, 1'b0, word);
    rd(ADDR_DATA, r); chk(r, wh | 8'h40);
    wr(ADDR_OFFS, OFF_RX_LO); rd(ADDR_DATA, r); chk(r, word[7:0]);
    // automatic mode sends its own page on every port
    @(posedge clk);
    auto_eee <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    for (int k = 0; k < 4; k++) chk(tx_page[k], {4'h2, tg[k], AUTO_CODE});
    report_and_stop();
  end
endmodule : tb_eee_next_page_transmit_regs
